// *** rtl/gtmms_pkg.sv ***
// Constants, register map and state types of the mode and status block
package gtmms_pkg;
   // Clock and timing
   localparam int unsigned GTMMS_CLK_HZ = 125_000_000;
   localparam int unsigned GTMMS_PWRUP_MS = 200;
   localparam int unsigned GTMMS_GINIT_MS = 1000;
   localparam int unsigned GTMMS_FLASH_HALF_MS = 500;
   localparam int unsigned GTMMS_MS_CYC = GTMMS_CLK_HZ / 1000;
   localparam int unsigned GTMMS_PWRUP_CYC = GTMMS_PWRUP_MS * GTMMS_MS_CYC;
   localparam int unsigned GTMMS_GINIT_CYC = GTMMS_GINIT_MS * GTMMS_MS_CYC;
   localparam int unsigned GTMMS_FLASH_CYC = GTMMS_FLASH_HALF_MS * GTMMS_MS_CYC;
   // Serial rates and their setting codes
   localparam int unsigned GTMMS_BPS_1200 = 1200;
   localparam int unsigned GTMMS_BPS_2400 = 2400;
   localparam int unsigned GTMMS_BPS_4800 = 4800;
   localparam int unsigned GTMMS_BPS_9600 = 9600;
   localparam int unsigned GTMMS_BPS_19200 = 19200;
   localparam int unsigned GTMMS_BPS_38400 = 38400;
   localparam logic [3:0] GTMMS_BAUD_MIN = 4'h3;
   localparam logic [3:0] GTMMS_BAUD_MAX = 4'h8;
   localparam int GTMMS_DIV_W = 17;
   // Frame: start, 8 data, stop
   localparam logic [3:0] GTMMS_FRAME_BITS = 4'hA;
   // Register byte offsets
   localparam logic [4:0] GTMMS_REG_STATUS = 5'h00;
   localparam logic [4:0] GTMMS_REG_SETTINGS = 5'h04;
   localparam logic [4:0] GTMMS_REG_FIX = 5'h08;
   localparam logic [4:0] GTMMS_REG_HOST_TX = 5'h0C;
   localparam logic [4:0] GTMMS_REG_GPS_TX = 5'h10;
   // Factory defaults
   localparam logic [3:0] GTMMS_DEF_BAUD = 4'h3;
   localparam logic GTMMS_DEF_DST = 1'b1;
   localparam logic GTMMS_DEF_H12 = 1'b0;
   localparam logic [3:0] GTMMS_DEF_TZ = 4'h8;
   localparam logic [7:0] GTMMS_DEF_NL = 8'h0D;
   localparam logic [3:0] GTMMS_TZ_MAX = 4'hB;
   // Satellite thresholds and limits
   localparam logic [3:0] GTMMS_SATS_FIRST = 4'h1;
   localparam logic [3:0] GTMMS_SATS_LOCK = 4'h4;
   localparam logic [3:0] GTMMS_SATS_MAX = 4'hC;
   // Characters
   localparam logic [7:0] GTMMS_CH_DOLLAR = 8'h24;
   localparam logic [7:0] GTMMS_CH_STAR = 8'h2A;
   localparam logic [7:0] GTMMS_CH_G = 8'h47;
   localparam logic [7:0] GTMMS_CH_P = 8'h50;
   localparam logic [7:0] GTMMS_CH_CR = 8'h0D;
   localparam logic [7:0] GTMMS_CH_LF = 8'h0A;
   localparam logic [7:0] GTMMS_CH_A = 8'h41;
   localparam logic [7:0] GTMMS_CH_V = 8'h56;
   localparam logic [7:0] GTMMS_CH_Y = 8'h59;
   localparam logic [7:0] GTMMS_CH_N = 8'h4E;
   localparam logic [7:0] GTMMS_CH_0 = 8'h30;
   localparam logic [7:0] GTMMS_CH_HEXA = 8'h37;
   // Sentence types, three letters each
   localparam int GTMMS_NTYPES = 6;
   localparam logic [23:0] GTMMS_TYPE_TBL [GTMMS_NTYPES] =
      '{24'h524D43, 24'h474741, 24'h475341, 24'h475356, 24'h474C4C, 24'h5A4441};
   // Sequencer lengths
   localparam logic [2:0] GTMMS_LEN_START = 3'h6;
   localparam logic [2:0] GTMMS_LEN_END = 3'h5;
   localparam logic [2:0] GTMMS_LEN_ONE = 3'h1;
   // Transmit operation codes in host write data bits 9:8
   typedef enum logic [1:0] {
      GTMMS_OP_BODY = 2'b00,
      GTMMS_OP_START = 2'b01,
      GTMMS_OP_END = 2'b10,
      GTMMS_OP_REPLY = 2'b11
   } gtmms_op_e;
   // Operating modes
   typedef enum logic [1:0] {
      GTMMS_MODE_QUERY = 2'b00,
      GTMMS_MODE_BCAST = 2'b01,
      GTMMS_MODE_GPS = 2'b11
   } gtmms_mode_e;
   // Status phases, Gray along the usual path
   typedef enum logic [2:0] {
      GTMMS_PH_PWRUP = 3'b000,
      GTMMS_PH_GINIT = 3'b001,
      GTMMS_PH_ACQ = 3'b011,
      GTMMS_PH_UNSYNC = 3'b010,
      GTMMS_PH_LOCK = 3'b110
   } gtmms_phase_e;
endpackage

// *** rtl/gtmms_top.sv ***
// Mode routing, sentence framing and status sequencing of the GPS time module
//
// Function
// - Config switch loops aux port to receiver
// - Config indicator follows config switch
// - Switch off: aux port passes to controller
// - Six selectable serial rates, 1200 to 38400
// - Query mode answers host commands
// - Broadcast mode sends unsolicited, ignores commands
// - Broadcast mode uses factory default settings
// - GPS mode emits the six standard sentences
// - Sentences start with GP talker
// - GLL status A valid, V invalid
// - GGA quality 0 none, 1 GPS, 2 differential
// - Satellites 00 to 12, station 0000-1023
// - RMC status A/V, date ddmmyy
// - ZDA date, year, zone fields
// - Load five settings, defaults if unmodified
// - Port uses stored rate, 8N1 framing
// - Power-up 200 ms, green flashing
// - Flag receiver init when it is silent
// - Receiver init 1 s, red flashes
// - First satellite gives unsynced data, N
// - Unsynced: green and red alternate
// - Four satellites lock, Y, green solid
// - Set commands unacknowledged, stored, used
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module gtmms_top
   import gtmms_pkg::*;
#(
   parameter int unsigned CLK_HZ = gtmms_pkg::GTMMS_CLK_HZ,
   parameter int unsigned PWRUP_CYC = gtmms_pkg::GTMMS_PWRUP_CYC,
   parameter int unsigned GINIT_CYC = gtmms_pkg::GTMMS_GINIT_CYC,
   parameter int unsigned FLASH_CYC = gtmms_pkg::GTMMS_FLASH_CYC
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Avalon-MM register slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Switches: config and the three operating mode positions
   input wire logic cfg_sw,
   input wire logic sel_query_response_mode,
   input wire logic sel_unsolicited_broadcast_mode,
   input wire logic sel_gps_mode,
   // Host controller serial port
   input wire logic host_rxd,
   output logic host_txd,
   output logic cmd_rxd,
   // Auxiliary port and controller side of its pass-through
   input wire logic aux_rxd,
   output logic aux_txd,
   input wire logic ctrl_aux_txd,
   output logic ctrl_aux_rxd,
   // Internal receiver serial port
   input wire logic gps_rxd,
   output logic gps_txd,
   // Indicators
   output logic cfg_led,
   output logic trk_green,
   output logic trk_red
);
   // Bit period for a rate code
   function automatic logic [GTMMS_DIV_W-1:0] baud_div(input logic [3:0] code);
      int unsigned d;
      d = CLK_HZ / GTMMS_BPS_1200;
      unique case (code)
         4'h4: d = CLK_HZ / GTMMS_BPS_2400;
         4'h5: d = CLK_HZ / GTMMS_BPS_4800;
         4'h6: d = CLK_HZ / GTMMS_BPS_9600;
         4'h7: d = CLK_HZ / GTMMS_BPS_19200;
         4'h8: d = CLK_HZ / GTMMS_BPS_38400;
         default: d = CLK_HZ / GTMMS_BPS_1200;
      endcase
      return d[GTMMS_DIV_W-1:0];
   endfunction

   // Byte-lane merge for register writes
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ASCII upper-case hex digit
   function automatic logic [7:0] hex_ch(input logic [3:0] n);
      return (n > 4'h9) ? (GTMMS_CH_HEXA + {4'h0, n}) : (GTMMS_CH_0 + {4'h0, n});
   endfunction

   // Mode, phase and timers
   gtmms_mode_e mode_q; // Operating mode in force
   gtmms_phase_e phase_q, phase_d; // Status phase
   logic [31:0] ph_cnt_q; // Cycles spent in the timed phases
   logic [31:0] fl_cnt_q; // Flash half-period counter
   logic blink_q; // Indicator flash phase, toggles every half second
   logic gps_rxd_q; // Previous receiver line level for edge detect
   logic gps_seen_q; // Receiver produced output during init phase
   logic need_init_q; // Receiver was silent: init commands are due
   // Stored settings and the active rate
   logic [3:0] baud_q, tz_q, baud_act_q;
   logic dst_q, h12_q, modified_q;
   logic [7:0] nl_q;
   // Fix information written by the parsing firmware
   logic [3:0] sats_q;
   logic diff_q;
   logic [9:0] stn_q;
   // Sentence sequencer
   gtmms_op_e op_q; // Operation in progress
   logic busy_q; // Sequencer is sending
   logic [2:0] idx_q; // Character index in operation
   logic [7:0] arg_q; // Body character or type index
   logic [7:0] cks_q; // Running XOR checksum
   // Bus read pipeline
   logic rd_ack_q;
   logic [31:0] rdata_q;
   // Transmitter handshakes
   logic host_ready, gps_ready, host_uart_txd, gps_uart_txd;

   // Mode selector decode, one-hot only
   wire [2:0] sel = {sel_gps_mode, sel_unsolicited_broadcast_mode, sel_query_response_mode};
   wire sel_one_hot = (sel == 3'b001) || (sel == 3'b010) || (sel == 3'b100);
   wire is_query = (mode_q == GTMMS_MODE_QUERY);
   wire is_bcast = (mode_q == GTMMS_MODE_BCAST);
   wire early = (phase_q == GTMMS_PH_PWRUP) || (phase_q == GTMMS_PH_GINIT);

   // Effective settings: broadcast ignores what was stored
   wire [3:0] eff_baud = is_bcast ? GTMMS_DEF_BAUD : baud_q;
   wire [7:0] eff_nl = is_bcast ? GTMMS_DEF_NL : nl_q;
   wire eff_dst = is_bcast ? GTMMS_DEF_DST : dst_q;
   wire eff_h12 = is_bcast ? GTMMS_DEF_H12 : h12_q;
   wire [3:0] eff_tz = is_bcast ? GTMMS_DEF_TZ : tz_q;

   // Status characters for sentence fields
   wire locked = (phase_q == GTMMS_PH_LOCK);
   wire [7:0] valid_ch = locked ? GTMMS_CH_A : GTMMS_CH_V;
   wire [7:0] sync_ch = locked ? GTMMS_CH_Y : GTMMS_CH_N;
   wire [1:0] qual = (sats_q == 4'h0) ? 2'h0 : (diff_q ? 2'h2 : 2'h1);
   wire [7:0] qual_ch = GTMMS_CH_0 + {6'h00, qual};

   // Bus decode
   wire a_status = (avs_address == GTMMS_REG_STATUS);
   wire a_set = (avs_address == GTMMS_REG_SETTINGS);
   wire a_fix = (avs_address == GTMMS_REG_FIX);
   wire a_htx = (avs_address == GTMMS_REG_HOST_TX);
   wire a_gtx = (avs_address == GTMMS_REG_GPS_TX);
   // Transmit writes stall while their path is busy
   wire htx_stall = avs_write && a_htx && busy_q;
   wire gtx_stall = avs_write && a_gtx && !gps_ready;
   assign avs_waitrequest = (avs_read && !rd_ack_q) || htx_stall || gtx_stall;
   assign avs_readdata = rdata_q;
   wire wr_set = avs_write && a_set && is_query && !early;
   wire wr_fix = avs_write && a_fix;
   wire htx_take = avs_write && a_htx && !busy_q && avs_byteenable[1];
   wire htx_go = htx_take && !early && (avs_writedata[2:0] < 3'(GTMMS_NTYPES)
                 || avs_writedata[9:8] != GTMMS_OP_START);
   wire gps_go = avs_write && a_gtx && gps_ready && avs_byteenable[0];

   // Settings write with range checks
   wire [31:0] set_rd = {8'h00, nl_q, modified_q, 3'h0, tz_q, 2'h0, h12_q, dst_q, baud_q};
   wire [31:0] set_wd = be_merge(set_rd, avs_writedata, avs_byteenable);
   wire baud_ok = (set_wd[3:0] >= GTMMS_BAUD_MIN) && (set_wd[3:0] <= GTMMS_BAUD_MAX);
   wire tz_ok = (set_wd[11:8] <= GTMMS_TZ_MAX);
   wire [31:0] fix_rd = {6'h00, stn_q, 11'h000, diff_q, sats_q};
   wire [31:0] fix_wd = be_merge(fix_rd, avs_writedata, avs_byteenable);
   wire [3:0] sats_wd = (fix_wd[3:0] > GTMMS_SATS_MAX) ? GTMMS_SATS_MAX : fix_wd[3:0];

   // Read mux; unmapped offsets read as zero
   wire [31:0] status_rd = {qual_ch, valid_ch, sync_ch, need_init_q, gps_seen_q, cfg_sw,
                            mode_q, phase_q};
   wire [31:0] rd_mux = a_status ? status_rd : a_set ? set_rd : a_fix ? fix_rd :
                        32'h0000_0000;

   // Sequencer character select
   wire [23:0] type_ltr = GTMMS_TYPE_TBL[arg_q[2:0]];
   logic [7:0] cur_ch;
   logic [2:0] op_len;
   always_comb
   begin
      cur_ch = arg_q;
      op_len = GTMMS_LEN_ONE;
      unique case (op_q)
         GTMMS_OP_START:
         begin
            op_len = GTMMS_LEN_START;
            unique case (idx_q)
               3'h0: cur_ch = GTMMS_CH_DOLLAR;
               3'h1: cur_ch = GTMMS_CH_G;
               3'h2: cur_ch = GTMMS_CH_P;
               3'h3: cur_ch = type_ltr[23:16];
               3'h4: cur_ch = type_ltr[15:8];
               default: cur_ch = type_ltr[7:0];
            endcase
         end
         GTMMS_OP_END:
         begin
            op_len = GTMMS_LEN_END;
            unique case (idx_q)
               3'h0: cur_ch = GTMMS_CH_STAR;
               3'h1: cur_ch = hex_ch(cks_q[7:4]);
               3'h2: cur_ch = hex_ch(cks_q[3:0]);
               3'h3: cur_ch = GTMMS_CH_CR;
               default: cur_ch = GTMMS_CH_LF;
            endcase
         end
         GTMMS_OP_REPLY: cur_ch = eff_nl;
         GTMMS_OP_BODY: cur_ch = arg_q;
      endcase
   end
   wire send = busy_q && host_ready;
   wire last = (idx_q == op_len - 3'h1);
   // XOR covers everything after the dollar and before the star
   wire in_sum = (op_q == GTMMS_OP_BODY) || ((op_q == GTMMS_OP_START) && (idx_q != 3'h0));

   // Phase sequencing
   wire ph_end_pw = (ph_cnt_q >= PWRUP_CYC - 1);
   wire ph_end_gi = (ph_cnt_q >= GINIT_CYC - 1);
   always_comb
   begin
      phase_d = phase_q;
      unique case (phase_q)
         GTMMS_PH_PWRUP: if (ph_end_pw) phase_d = GTMMS_PH_GINIT;
         GTMMS_PH_GINIT: if (ph_end_gi) phase_d = GTMMS_PH_ACQ;
         GTMMS_PH_ACQ: if (sats_q >= GTMMS_SATS_FIRST) phase_d = GTMMS_PH_UNSYNC;
         GTMMS_PH_UNSYNC: if (sats_q >= GTMMS_SATS_LOCK) phase_d = GTMMS_PH_LOCK;
         GTMMS_PH_LOCK: if (sats_q < GTMMS_SATS_LOCK) phase_d = GTMMS_PH_UNSYNC;
         default: phase_d = GTMMS_PH_PWRUP;
      endcase
   end

   // Mode register: a selector between positions keeps the last mode
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         mode_q <= GTMMS_MODE_QUERY;
      else if (sel_one_hot)
         mode_q <= sel_gps_mode ? GTMMS_MODE_GPS :
                   sel_unsolicited_broadcast_mode ? GTMMS_MODE_BCAST :
                   GTMMS_MODE_QUERY;
   end

   // Phase register, timer and receiver check
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_q <= GTMMS_PH_PWRUP;
         ph_cnt_q <= 32'h0000_0000;
         gps_rxd_q <= 1'b1;
         gps_seen_q <= 1'b0;
         need_init_q <= 1'b0;
      end
      else
      begin
         phase_q <= phase_d;
         ph_cnt_q <= (phase_d != phase_q) ? 32'h0000_0000 : ph_cnt_q + 32'h0000_0001;
         gps_rxd_q <= gps_rxd;
         // Any start-bit edge counts as receiver output
         if (phase_q == GTMMS_PH_GINIT && gps_rxd_q && !gps_rxd)
            gps_seen_q <= 1'b1;
         if (phase_q == GTMMS_PH_GINIT && ph_end_gi)
            need_init_q <= !gps_seen_q;
         else if (gps_go)
            need_init_q <= 1'b0;
      end
   end

   // Flash timer: free running so all patterns share one beat
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fl_cnt_q <= 32'h0000_0000;
         blink_q <= 1'b0;
      end
      else if (fl_cnt_q >= FLASH_CYC - 1)
      begin
         fl_cnt_q <= 32'h0000_0000;
         blink_q <= !blink_q;
      end
      else
         fl_cnt_q <= fl_cnt_q + 32'h0000_0001;
   end

   // Tracking indicator patterns per phase
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trk_green <= 1'b0;
         trk_red <= 1'b0;
      end
      else
      begin
         unique case (phase_q)
            GTMMS_PH_PWRUP: {trk_green, trk_red} <= {blink_q, 1'b0};
            GTMMS_PH_GINIT, GTMMS_PH_ACQ: {trk_green, trk_red} <= {1'b0, blink_q};
            GTMMS_PH_UNSYNC: {trk_green, trk_red} <= {blink_q, !blink_q};
            GTMMS_PH_LOCK: {trk_green, trk_red} <= {1'b1, blink_q};
            default: {trk_green, trk_red} <= 2'b00;
         endcase
      end
   end

   // Stored settings; set writes are silent, software reads back to confirm
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         baud_q <= GTMMS_DEF_BAUD;
         dst_q <= GTMMS_DEF_DST;
         h12_q <= GTMMS_DEF_H12;
         tz_q <= GTMMS_DEF_TZ;
         nl_q <= GTMMS_DEF_NL;
         modified_q <= 1'b0;
      end
      else if (wr_set)
      begin
         // Out-of-range codes leave the old value in place
         if (baud_ok)
            baud_q <= set_wd[3:0];
         if (tz_ok)
            tz_q <= set_wd[11:8];
         dst_q <= set_wd[4];
         h12_q <= set_wd[5];
         nl_q <= set_wd[23:16];
         modified_q <= 1'b1;
      end
   end

   // Active rate: default in power-up, then the effective setting
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         baud_act_q <= GTMMS_DEF_BAUD;
      else if (phase_q != GTMMS_PH_PWRUP)
         baud_act_q <= eff_baud;
   end

   // Fix information; satellite count clamps at twelve
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sats_q <= 4'h0;
         diff_q <= 1'b0;
         stn_q <= 10'h000;
      end
      else if (wr_fix)
      begin
         sats_q <= sats_wd;
         diff_q <= fix_wd[4];
         stn_q <= fix_wd[25:16];
      end
   end

   // Sentence sequencer and checksum
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op_q <= GTMMS_OP_BODY;
         busy_q <= 1'b0;
         idx_q <= 3'h0;
         arg_q <= 8'h00;
         cks_q <= 8'h00;
      end
      else if (htx_go)
      begin
         op_q <= gtmms_op_e'(avs_writedata[9:8]);
         arg_q <= avs_writedata[7:0];
         busy_q <= 1'b1;
         idx_q <= 3'h0;
         if (avs_writedata[9:8] == GTMMS_OP_START)
            cks_q <= 8'h00;
      end
      else if (send)
      begin
         if (in_sum)
            cks_q <= cks_q ^ cur_ch;
         idx_q <= idx_q + 3'h1;
         if (last)
            busy_q <= 1'b0;
      end
   end

   // Bus read: registered data, one wait state
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         rd_ack_q <= avs_read && !rd_ack_q;
         if (avs_read && !rd_ack_q)
            rdata_q <= rd_mux;
      end
   end

   // Host-side transmitter, every mode
   gtmms_uart_tx u_host_tx (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .div(baud_div(baud_act_q)),
      .tx_valid(busy_q),
      .tx_data(cur_ch),
      .tx_ready(host_ready),
      .txd(host_uart_txd)
   );

   // Receiver-side transmitter
   gtmms_uart_tx u_gps_tx (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .div(baud_div(baud_act_q)),
      .tx_valid(gps_go),
      .tx_data(avs_writedata[7:0]),
      .tx_ready(gps_ready),
      .txd(gps_uart_txd)
   );

   // Port routing; pass-through is pure wiring so no bit timing is lost
   assign host_txd = host_uart_txd;
   assign cmd_rxd = (is_query && !early) ? host_rxd : 1'b1;
   assign aux_txd = cfg_sw ? gps_rxd : ctrl_aux_txd;
   assign ctrl_aux_rxd = cfg_sw ? 1'b1 : aux_rxd;
   assign gps_txd = cfg_sw ? aux_rxd : gps_uart_txd;
   assign cfg_led = cfg_sw;

   // Time settings are used by firmware only
   wire unused_ok = eff_dst ^ eff_h12 ^ (^eff_tz);
endmodule
`default_nettype wire

// *** rtl/gtmms_uart_tx.sv ***
// Serial transmitter, 8 data bits, no parity, 1 stop bit
`timescale 1ns/1ps
`default_nettype none
module gtmms_uart_tx
   import gtmms_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Bit period in clock cycles
   input wire logic [GTMMS_DIV_W-1:0] div,
   // Byte stream
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   // Serial line
   output logic txd
);
   logic [9:0] shift_q; // Frame being sent, LSB first
   logic [3:0] bits_q; // Bits left in the frame
   logic [GTMMS_DIV_W-1:0] tick_q; // Bit period counter
   wire tick_done = (tick_q == '0);
   wire busy = (bits_q != 4'h0);

   assign tx_ready = !busy;
   assign txd = shift_q[0];

   // Load a frame when idle, shift one bit per period
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_q <= 10'h3FF;
         bits_q <= 4'h0;
         tick_q <= '0;
      end
      else if (!busy)
      begin
         // Divisor sampled at load and after every bit, so a rate change can split a byte
         if (tx_valid)
         begin
            shift_q <= {1'b1, tx_data, 1'b0};
            bits_q <= GTMMS_FRAME_BITS;
            tick_q <= div - 1'b1;
         end
      end
      else if (tick_done)
      begin
         shift_q <= {1'b1, shift_q[9:1]};
         bits_q <= bits_q - 4'h1;
         tick_q <= div - 1'b1;
      end
      else
      begin
         tick_q <= tick_q - 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** sim/gtmms_host_model.sv ***
// Controller model: samples the block's frames
`timescale 1ns/1ps
`default_nettype none
module gtmms_host_model #(parameter int BIT_CYC = 31)
(
   // Clock
   input wire logic core_clk,
   // Serial lines
   input wire logic rxd,
   output logic txd
);
   logic [7:0] q [$]; // Received bytes, oldest first
   logic [7:0] sh; // Data shift
   initial txd = 1'b1; // Idle mark; no commands sent
   // Mid-bit sampling of 8 data LSB first and stop, timed from the start edge; start bit not checked
   always
   begin
      @(negedge rxd);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 9; i++)
      begin
         repeat (BIT_CYC) @(posedge core_clk);
         if (i < 8) sh[i] = rxd;
      end
      q.push_back(rxd ? sh : 8'h00);
   end
endmodule
`default_nettype wire

// *** sim/gtmms_sva.sv ***
// Port checker for routing, indicators and start-up quiet
`timescale 1ns/1ps
`default_nettype none
module gtmms_sva #(parameter int unsigned PWRUP_CYC = 20, parameter int unsigned GINIT_CYC = 50)
(
   // Clock, reset, bus
   input wire logic core_clk, rst_n, avs_read, avs_waitrequest,
   // Serial routing
   input wire logic cfg_sw, host_rxd, cmd_rxd, host_txd, aux_rxd, aux_txd,
   input wire logic ctrl_aux_txd, ctrl_aux_rxd, gps_rxd, gps_txd,
   // Indicators
   input wire logic cfg_led, trk_green, trk_red
);
   logic [7:0] cyc_q; // Cycles since reset, saturating
   // Count cycles since reset
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n) cyc_q <= 8'h00;
      else if (cyc_q != 8'hFF) cyc_q <= cyc_q + 8'h01;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_cfg_led_follows: assert property (cfg_led == cfg_sw) else $error("cfg led");
   chk_aux_loop_back: assert property (cfg_sw |-> aux_txd == gps_rxd && gps_txd == aux_rxd && ctrl_aux_rxd) else $error("loop");
   chk_aux_pass_through: assert property (!cfg_sw |-> aux_txd == ctrl_aux_txd && ctrl_aux_rxd == aux_rxd) else $error("pass");
   chk_read_one_wait: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("wait");
   chk_cmd_gate_idle: assert property (!cmd_rxd |-> !host_rxd) else $error("gate");
   chk_pwrup_no_red: assert property (cyc_q < PWRUP_CYC |-> !trk_red) else $error("red");
   chk_ginit_no_green: assert property (cyc_q > PWRUP_CYC + 1 && cyc_q < PWRUP_CYC + GINIT_CYC |-> !trk_green) else $error("green");
   // Margin of two cycles covers the phase register lag
   chk_start_quiet: assert property (cyc_q < PWRUP_CYC + GINIT_CYC - 2 |-> host_txd && cmd_rxd) else $error("quiet");
endmodule
`default_nettype wire

// *** sim/tb_gps_time_module_mode_status.sv ***
// Self-checking bench for the GPS time module block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb_gps_time_module_mode_status;
   import gtmms_pkg::*;
   // Bus and clock
   logic core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
   logic [3:0] avs_byteenable = 4'hF;
   // Switches and lines
   logic cfg_sw = 1'b0, sel_query_response_mode = 1'b1, sel_unsolicited_broadcast_mode = 1'b0;
   logic sel_gps_mode = 1'b0, aux_rxd = 1'b1, ctrl_aux_txd = 1'b1, gps_rxd = 1'b1;
   logic host_rxd, host_txd, cmd_rxd, aux_txd, ctrl_aux_rxd, gps_txd, cfg_led, trk_green, trk_red;
   int bad_count = 0, n_checks = 0;
   logic [7:0] cs, ex [11]; // Checksum, expected bytes
   gtmms_top #(.CLK_HZ(1_200_000), .PWRUP_CYC(20), .GINIT_CYC(50), .FLASH_CYC(10)) dut_u (.*);
   gtmms_host_model #(.BIT_CYC(31)) host_u (.core_clk(core_clk), .rxd(host_txd), .txd(host_rxd));
   always #4 core_clk = ~core_clk;
   // One bus transfer, held until waitrequest is low
   task bus_op(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   function automatic logic [7:0] hexc(input logic [3:0] d);
      return (d < 4'hA) ? GTMMS_CH_0 + d : GTMMS_CH_HEXA + d;
   endfunction
   task s_start;
      bus_op(1'b1, GTMMS_REG_SETTINGS, 32'h18); // Too early: dropped
      bus_op(1'b0, GTMMS_REG_SETTINGS, 32'h0);
      `CHK("settings", {8'h0D, 4'h0, GTMMS_DEF_TZ, 2'b00, GTMMS_DEF_H12, GTMMS_DEF_DST, GTMMS_DEF_BAUD}, rdat[23:0])
      bus_op(1'b0, 5'h14, 32'h0);
      `CHK("unmapped", 32'h0, rdat)
      repeat (80) @(posedge core_clk);
      bus_op(1'b0, GTMMS_REG_STATUS, 32'h0);
      `CHK("acq", {GTMMS_CH_N, 1'b1, 4'h0, GTMMS_PH_ACQ}, rdat[15:0])
      bus_op(1'b1, GTMMS_REG_GPS_TX, 32'h55);
      bus_op(1'b0, GTMMS_REG_STATUS, 32'h0);
      `CHK("init", 1'b0, rdat[7])
   endtask
   task s_rate;
      bus_op(1'b1, GTMMS_REG_SETTINGS, 32'h000D0818);
      bus_op(1'b0, GTMMS_REG_SETTINGS, 32'h0);
      `CHK("rate", 12'h818, rdat[11:0])
      bus_op(1'b1, GTMMS_REG_SETTINGS, 32'h000D0819); // Reserved code keeps the rate
      bus_op(1'b0, GTMMS_REG_SETTINGS, 32'h0);
      `CHK("bad rate", 4'h8, rdat[3:0])
   endtask
   task s_sentence;
      bus_op(1'b1, GTMMS_REG_HOST_TX, 32'h104);
      bus_op(1'b1, GTMMS_REG_HOST_TX, 32'h200);
      cs = 8'h47 ^ 8'h50 ^ 8'h47 ^ 8'h4C ^ 8'h4C;
      ex = '{GTMMS_CH_DOLLAR, GTMMS_CH_G, GTMMS_CH_P, 8'h47, 8'h4C, 8'h4C, GTMMS_CH_STAR,
         hexc(cs[7:4]), hexc(cs[3:0]), GTMMS_CH_CR, GTMMS_CH_LF};
      for (int i = 0; i < 6000 && host_u.q.size() < 11; i++) @(posedge core_clk);
      foreach (ex[i]) `CHK("byte", ex[i], host_u.q[i])
   endtask
   task s_track;
      bus_op(1'b1, GTMMS_REG_FIX, 32'h4);
      repeat (2) @(posedge core_clk);
      bus_op(1'b0, GTMMS_REG_STATUS, 32'h0);
      `CHK("lock", {GTMMS_CH_Y, GTMMS_PH_LOCK}, {rdat[15:8], rdat[2:0]})
      repeat (3) @(negedge core_clk);
      `CHK("solid", 1'b1, trk_green)
      bus_op(1'b1, GTMMS_REG_FIX, 32'h1);
      bus_op(1'b0, GTMMS_REG_STATUS, 32'h0);
      `CHK("unsync", {GTMMS_CH_N, GTMMS_PH_UNSYNC}, {rdat[15:8], rdat[2:0]})
      repeat (3) @(negedge core_clk);
      `CHK("alt", ~trk_green, trk_red)
   endtask
   // Set selector {gps,bcast,query}, read mode back
   task sw(input logic [2:0] s, input logic [1:0] m);
      @(posedge core_clk);
      {sel_gps_mode, sel_unsolicited_broadcast_mode, sel_query_response_mode} <= s;
      bus_op(1'b0, GTMMS_REG_STATUS, 32'h0);
      `CHK("mode", m, rdat[4:3])
   endtask
   task s_modes;
      sw(3'b010, GTMMS_MODE_BCAST);
      bus_op(1'b1, GTMMS_REG_SETTINGS, 32'h000D0815); // Ignored while broadcasting
      bus_op(1'b0, GTMMS_REG_SETTINGS, 32'h0);
      `CHK("bcast set", 4'h8, rdat[3:0])
      sw(3'b100, GTMMS_MODE_GPS);
      sw(3'b101, GTMMS_MODE_GPS); // Two positions at once hold the old mode
      sw(3'b001, GTMMS_MODE_QUERY);
   endtask
   task s_cfg;
      @(posedge core_clk);
      cfg_sw <= 1'b1;
      aux_rxd <= 1'b0;
      gps_rxd <= 1'b0;
      @(negedge core_clk);
      `CHK("cfg on", 4'b1001, {cfg_led, gps_txd, aux_txd, ctrl_aux_rxd})
      @(posedge core_clk);
      cfg_sw <= 1'b0;
      ctrl_aux_txd <= 1'b0;
      @(negedge core_clk);
      `CHK("cfg off", 3'b000, {cfg_led, aux_txd, ctrl_aux_rxd})
   endtask
   task wrap_up;
      if (bad_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      s_start;
      s_rate;
      s_sentence;
      s_track;
      s_modes;
      s_cfg;
      wrap_up;
   end
   // Watchdog
   initial
   begin
      repeat (30000) @(posedge core_clk);
      bad_count++;
      wrap_up;
   end
endmodule
bind gtmms_top gtmms_sva #(.PWRUP_CYC(PWRUP_CYC), .GINIT_CYC(GINIT_CYC)) chk_u (.*);
`default_nettype wire
